// File: io_link_defs.svh
`ifndef IO_LINK_DEFS_SVH
`define IO_LINK_DEFS_SVH

// register byte offsets
`define OFS_PF_WIN0_ENABLE 8'he0
`define OFS_PF_WIN0_BASE 8'he4
`define OFS_PF_WIN1_ENABLE 8'he8
`define OFS_PF_WIN1_BASE 8'hec
`define OFS_NC_WIN0_ENABLE 8'hf0
`define OFS_NC_WIN0_BASE 8'hf4
`define OFS_NC_WIN1_ENABLE 8'hf8
`define OFS_NC_WIN1_BASE 8'hfc
`define OFS_WIN_STATUS 8'h00

// field positions
`define FLD_WIN_ON 31
`define FLD_NC_REMAP_ON 30
`define FLD_NC_XLATE_MSB 29
`define FLD_PF_XLATE_MSB 15
`define FLD_BASE_MSB 31
`define FLD_BASE_LSB 16
`define FLD_MASK_MSB 15

// address geometry: windows compare bits 39:24, remap reaches bit 53
`define WIN_CMP_LSB 24
`define WIN_CMP_MSB 39
`define XLATE_MSB 53

// reset values
`define RST_REG32 32'h0000_0000
`define RST_FIELD16 16'h0000
`define RST_FIELD30 30'h0000_0000

`endif

// File: io_link_pkg.sv
package io_link_pkg;
    // progress of a missed prefetch-window read that owes invalid beats
    typedef enum logic [0:0] {
        DRAIN_IDLE = 1'b0,
        DRAIN_BUSY = 1'b1
    } drain_state_type;

    // where an inbound link request is steered
    typedef enum logic [0:0] {
        ROUTE_COHERENT = 1'b0,
        ROUTE_DIRECT = 1'b1
    } route_type;
endpackage

// File: window_if.sv
`timescale 1ns/1ps
// one address window: settings and probe address in, verdict out
interface window_if;
    logic on;
    logic remap_on;
    logic [15:0] base;
    logic [15:0] mask;
    logic [29:0] xlate;
    logic [39:0] addr;
    logic hit;
    logic [53:0] out_addr;

    modport ctrl (
        output on, remap_on, base, mask, xlate, addr,
        input hit, out_addr
    );
    modport match (
        input on, remap_on, base, mask, xlate, addr,
        output hit, out_addr
    );
endinterface

// File: window_match.sv
`timescale 1ns/1ps
`include "io_link_defs.svh"
// combinational compare and remap for one window
module window_match (
    window_if.match win
);
    logic [15:0] upper;
    logic [15:0] merged;

    // a set mask bit takes part in the compare
    always_comb begin
        upper = win.addr[`WIN_CMP_MSB:`WIN_CMP_LSB];
        win.hit = win.on && ((upper & win.mask) == (win.base & win.mask));
        // masked bits come from the translation, the rest pass through
        merged = (upper & ~win.mask) | (win.xlate[15:0] & win.mask);
        if (win.hit && win.remap_on) begin
            win.out_addr = {win.xlate[29:16], merged, win.addr[`WIN_CMP_LSB-1:0]};
        end else begin
            win.out_addr = {14'h0, win.addr};
        end
    end
endmodule // window_match

// File: io_link_address_windows.sv
// Local design decision: the strobed register port.
`timescale 1ns/1ps
`include "io_link_defs.svh"
// Summary of operation
// - uncache windows are matched on addresses arriving from the link.
// - an inbound uncache hit bypasses the shared cache, going straight to memory.
// - an inbound uncache hit invalidates no first-level cache line.
// - uncache enable bit 31 turns the window on; clear means no hit; resets zero.
// - uncache bit 30 turns address translation on for that window.
// - uncache enable bits 29:0 hold translated address bits 53:24.
// - uncache base register bits 31:16 hold base address bits 39:24.
// - uncache base register bits 15:0 hold the compare mask over bits 39:24.
// - a second uncache window exists with enable bit 31, same behaviour.
// - second prefetch window enable bit 31 turns it on; resets zero.
// - prefetch enable bits 15:0 hold translated bits 39:24 applied on hit.
// - prefetch base register bits 31:16 hold base address bits 39:24.
// - prefetch base register bits 15:0 hold the mask over bits 39:24.
// - second prefetch base register: base in upper half, mask in lower half.
// - prefetch windows match core-side addresses; only hitting fetch/cache ops go out.
// - missing fetch/cache ops finish at once; reads get their count of invalid beats.
module io_link_address_windows #(
    parameter int BEAT_W = 4
) (
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_write_in,
    input wire logic reg_read_in,
    output logic [31:0] reg_rdata_out,
    input wire logic cpu_req_valid_in,
    input wire logic [39:0] cpu_req_addr_in,
    input wire logic cpu_req_write_in,
    input wire logic cpu_req_fetch_in,
    input wire logic [BEAT_W-1:0] cpu_req_len_in,
    output logic cpu_req_ready_out,
    output logic link_req_valid_out,
    output logic [39:0] link_req_addr_out,
    output logic link_req_write_out,
    output logic cpu_invalid_beat_out,
    output logic cpu_invalid_last_out,
    output logic cpu_write_done_out,
    input wire logic in_req_valid_in,
    input wire logic [39:0] in_req_addr_in,
    input wire logic in_req_write_in,
    output logic mem_req_valid_out,
    output logic [53:0] mem_req_addr_out,
    output logic mem_req_write_out,
    output io_link_pkg::route_type mem_req_route_out,
    output logic mem_req_l1_invalidate_out
);
    import io_link_pkg::*;

    // the drain counter serves 1 to 8 length bits
    if (BEAT_W < 1 || BEAT_W > 8) begin : gen_check_beat_w
        $error("BEAT_W must lie in 1..8");
    end

    // window settings: index 0 and 1 of each kind
    logic pf_win_on [2];
    logic [15:0] pf_win_xlate_addr [2];
    logic [15:0] pf_win_base_addr [2];
    logic [15:0] pf_win_addr_mask [2];
    logic nc_win_on [2];
    logic nc_win_remap_on [2];
    logic [29:0] nc_win_xlate_addr [2];
    logic [15:0] nc_win_base_addr [2];
    logic [15:0] nc_win_addr_mask [2];
    logic next_pf_win_on [2];
    logic [15:0] next_pf_win_xlate_addr [2];
    logic [15:0] next_pf_win_base_addr [2];
    logic [15:0] next_pf_win_addr_mask [2];
    logic next_nc_win_on [2];
    logic next_nc_win_remap_on [2];
    logic [29:0] next_nc_win_xlate_addr [2];
    logic [15:0] next_nc_win_base_addr [2];
    logic [15:0] next_nc_win_addr_mask [2];
    logic [31:0] next_reg_rdata;

    // status counters shown to software
    logic [15:0] drop_count;
    logic [15:0] direct_count;
    logic [15:0] next_drop_count;
    logic [15:0] next_direct_count;

    // request path state
    drain_state_type drain_state;
    drain_state_type next_drain_state;
    logic [BEAT_W-1:0] beats_left;
    logic [BEAT_W-1:0] next_beats_left;
    logic next_cpu_req_ready;
    logic next_link_req_valid;
    logic [39:0] next_link_req_addr;
    logic next_link_req_write;
    logic next_cpu_invalid_beat;
    logic next_cpu_invalid_last;
    logic next_cpu_write_done;
    logic next_mem_req_valid;
    logic [53:0] next_mem_req_addr;
    logic next_mem_req_write;
    route_type next_mem_req_route;
    logic next_mem_req_l1_invalidate;

    logic cpu_take;
    logic pf_hit;
    logic [53:0] pf_addr;
    logic nc_hit;
    logic [53:0] nc_addr;

    window_if pf_win [2] ();
    window_if nc_win [2] ();

    // pack a register image from its fields
    function automatic logic [31:0] pack_base(input logic [15:0] base, input logic [15:0] mask);
        return {base, mask};
    endfunction

    // the four windows share one matcher design
    for (genvar i = 0; i < 2; i++) begin : gen_win
        // prefetch windows always remap on hit; their translation is 16 bits
        assign pf_win[i].on = pf_win_on[i];
        assign pf_win[i].remap_on = 1'b1;
        assign pf_win[i].base = pf_win_base_addr[i];
        assign pf_win[i].mask = pf_win_addr_mask[i];
        assign pf_win[i].xlate = {14'h0, pf_win_xlate_addr[i]};
        assign pf_win[i].addr = cpu_req_addr_in;
        // uncache windows see only inbound link addresses
        assign nc_win[i].on = nc_win_on[i];
        assign nc_win[i].remap_on = nc_win_remap_on[i];
        assign nc_win[i].base = nc_win_base_addr[i];
        assign nc_win[i].mask = nc_win_addr_mask[i];
        assign nc_win[i].xlate = nc_win_xlate_addr[i];
        assign nc_win[i].addr = in_req_addr_in;
        window_match u_pf_match (.win(pf_win[i]));
        window_match u_nc_match (.win(nc_win[i]));
    end

    // window 0 has priority when two windows overlap
    always_comb begin
        pf_hit = pf_win[0].hit || pf_win[1].hit;
        pf_addr = pf_win[0].hit ? pf_win[0].out_addr : pf_win[1].out_addr;
        nc_hit = in_req_valid_in && (nc_win[0].hit || nc_win[1].hit);
        nc_addr = nc_win[0].hit ? nc_win[0].out_addr : nc_win[1].out_addr;
    end

    // register writes and the one-cycle-late read data
    always_comb begin
        next_pf_win_on = pf_win_on;
        next_pf_win_xlate_addr = pf_win_xlate_addr;
        next_pf_win_base_addr = pf_win_base_addr;
        next_pf_win_addr_mask = pf_win_addr_mask;
        next_nc_win_on = nc_win_on;
        next_nc_win_remap_on = nc_win_remap_on;
        next_nc_win_xlate_addr = nc_win_xlate_addr;
        next_nc_win_base_addr = nc_win_base_addr;
        next_nc_win_addr_mask = nc_win_addr_mask;
        next_reg_rdata = `RST_REG32;
        if (reg_write_in) begin
            unique case (reg_addr_in)
                `OFS_PF_WIN0_ENABLE, `OFS_PF_WIN1_ENABLE: begin
                    next_pf_win_on[reg_addr_in[3]] = reg_wdata_in[`FLD_WIN_ON];
                    next_pf_win_xlate_addr[reg_addr_in[3]] =
                        reg_wdata_in[`FLD_PF_XLATE_MSB:0];
                end
                `OFS_PF_WIN0_BASE, `OFS_PF_WIN1_BASE: begin
                    next_pf_win_base_addr[reg_addr_in[3]] =
                        reg_wdata_in[`FLD_BASE_MSB:`FLD_BASE_LSB];
                    next_pf_win_addr_mask[reg_addr_in[3]] =
                        reg_wdata_in[`FLD_MASK_MSB:0];
                end
                `OFS_NC_WIN0_ENABLE, `OFS_NC_WIN1_ENABLE: begin
                    next_nc_win_on[reg_addr_in[3]] = reg_wdata_in[`FLD_WIN_ON];
                    next_nc_win_remap_on[reg_addr_in[3]] = reg_wdata_in[`FLD_NC_REMAP_ON];
                    next_nc_win_xlate_addr[reg_addr_in[3]] =
                        reg_wdata_in[`FLD_NC_XLATE_MSB:0];
                end
                `OFS_NC_WIN0_BASE, `OFS_NC_WIN1_BASE: begin
                    next_nc_win_base_addr[reg_addr_in[3]] =
                        reg_wdata_in[`FLD_BASE_MSB:`FLD_BASE_LSB];
                    next_nc_win_addr_mask[reg_addr_in[3]] = reg_wdata_in[`FLD_MASK_MSB:0];
                end
                default: begin
                end
            endcase
        end
        // unmapped addresses and reserved bits read as zero
        if (reg_read_in) begin
            unique case (reg_addr_in)
                `OFS_PF_WIN0_ENABLE, `OFS_PF_WIN1_ENABLE:
                    next_reg_rdata = {pf_win_on[reg_addr_in[3]], 15'h0,
                        pf_win_xlate_addr[reg_addr_in[3]]};
                `OFS_PF_WIN0_BASE, `OFS_PF_WIN1_BASE:
                    next_reg_rdata = pack_base(pf_win_base_addr[reg_addr_in[3]],
                        pf_win_addr_mask[reg_addr_in[3]]);
                `OFS_NC_WIN0_ENABLE, `OFS_NC_WIN1_ENABLE:
                    next_reg_rdata = {nc_win_on[reg_addr_in[3]], nc_win_remap_on[reg_addr_in[3]],
                        nc_win_xlate_addr[reg_addr_in[3]]};
                `OFS_NC_WIN0_BASE, `OFS_NC_WIN1_BASE:
                    next_reg_rdata = pack_base(nc_win_base_addr[reg_addr_in[3]],
                        nc_win_addr_mask[reg_addr_in[3]]);
                `OFS_WIN_STATUS:
                    next_reg_rdata = {drop_count, direct_count};
                default:
                    next_reg_rdata = `RST_REG32;
            endcase
        end
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            for (int i = 0; i < 2; i++) begin
                pf_win_on[i] <= 1'b0;
                pf_win_xlate_addr[i] <= `RST_FIELD16;
                pf_win_base_addr[i] <= `RST_FIELD16;
                pf_win_addr_mask[i] <= `RST_FIELD16;
                nc_win_on[i] <= 1'b0;
                nc_win_remap_on[i] <= 1'b0;
                nc_win_xlate_addr[i] <= `RST_FIELD30;
                nc_win_base_addr[i] <= `RST_FIELD16;
                nc_win_addr_mask[i] <= `RST_FIELD16;
            end
            reg_rdata_out <= `RST_REG32;
        end else begin
            pf_win_on <= next_pf_win_on;
            pf_win_xlate_addr <= next_pf_win_xlate_addr;
            pf_win_base_addr <= next_pf_win_base_addr;
            pf_win_addr_mask <= next_pf_win_addr_mask;
            nc_win_on <= next_nc_win_on;
            nc_win_remap_on <= next_nc_win_remap_on;
            nc_win_xlate_addr <= next_nc_win_xlate_addr;
            nc_win_base_addr <= next_nc_win_base_addr;
            nc_win_addr_mask <= next_nc_win_addr_mask;
            reg_rdata_out <= next_reg_rdata;
        end
    end

    assign cpu_take = cpu_req_valid_in && cpu_req_ready_out;

    // core side toward the link, link side toward memory
    always_comb begin
        next_drain_state = drain_state;
        next_beats_left = beats_left;
        next_link_req_valid = 1'b0;
        next_link_req_addr = link_req_addr_out;
        next_link_req_write = link_req_write_out;
        next_cpu_invalid_beat = 1'b0;
        next_cpu_invalid_last = 1'b0;
        next_cpu_write_done = 1'b0;
        next_drop_count = drop_count;
        next_direct_count = direct_count;
        unique case (drain_state)
            DRAIN_IDLE: begin
                if (cpu_take) begin
                    if (!cpu_req_fetch_in || pf_hit) begin
                        // other traffic passes as is; hitting fetch/cache ops are remapped
                        next_link_req_valid = 1'b1;
                        next_link_req_addr = cpu_req_fetch_in ? pf_addr[39:0] : cpu_req_addr_in;
                        next_link_req_write = cpu_req_write_in;
                    end else begin
                        next_drop_count = drop_count + 16'h1;
                        if (cpu_req_write_in) begin
                            next_cpu_write_done = 1'b1;
                        end else begin
                            // first invalid beat now, the rest from the drain state
                            next_cpu_invalid_beat = 1'b1;
                            next_cpu_invalid_last = (cpu_req_len_in == '0);
                            next_beats_left = cpu_req_len_in;
                            if (cpu_req_len_in != '0) begin
                                next_drain_state = DRAIN_BUSY;
                            end
                        end
                    end
                end
            end
            DRAIN_BUSY: begin
                next_cpu_invalid_beat = 1'b1;
                next_beats_left = beats_left - 1'b1;
                next_cpu_invalid_last = (beats_left == 1);
                if (beats_left == 1) begin
                    next_drain_state = DRAIN_IDLE;
                end
            end
        endcase
        // ready drops as soon as a read miss with more beats is taken
        next_cpu_req_ready = (next_drain_state == DRAIN_IDLE);
        // inbound: uncache hits go direct and leave the level-one caches alone
        next_mem_req_valid = in_req_valid_in;
        next_mem_req_write = in_req_write_in;
        next_mem_req_addr = nc_hit ? nc_addr : {14'h0, in_req_addr_in};
        next_mem_req_route = nc_hit ? ROUTE_DIRECT : ROUTE_COHERENT;
        next_mem_req_l1_invalidate = in_req_valid_in && !nc_hit;
        if (nc_hit) begin
            next_direct_count = direct_count + 16'h1;
        end
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            drain_state <= DRAIN_IDLE;
            beats_left <= '0;
            cpu_req_ready_out <= 1'b0;
            link_req_valid_out <= 1'b0;
            link_req_addr_out <= 40'h0;
            link_req_write_out <= 1'b0;
            cpu_invalid_beat_out <= 1'b0;
            cpu_invalid_last_out <= 1'b0;
            cpu_write_done_out <= 1'b0;
            mem_req_valid_out <= 1'b0;
            mem_req_addr_out <= 54'h0;
            mem_req_write_out <= 1'b0;
            mem_req_route_out <= ROUTE_COHERENT;
            mem_req_l1_invalidate_out <= 1'b0;
            drop_count <= 16'h0;
            direct_count <= 16'h0;
        end else begin
            drain_state <= next_drain_state;
            beats_left <= next_beats_left;
            cpu_req_ready_out <= next_cpu_req_ready;
            link_req_valid_out <= next_link_req_valid;
            link_req_addr_out <= next_link_req_addr;
            link_req_write_out <= next_link_req_write;
            cpu_invalid_beat_out <= next_cpu_invalid_beat;
            cpu_invalid_last_out <= next_cpu_invalid_last;
            cpu_write_done_out <= next_cpu_write_done;
            mem_req_valid_out <= next_mem_req_valid;
            mem_req_addr_out <= next_mem_req_addr;
            mem_req_write_out <= next_mem_req_write;
            mem_req_route_out <= next_mem_req_route;
            mem_req_l1_invalidate_out <= next_mem_req_l1_invalidate;
            drop_count <= next_drop_count;
            direct_count <= next_direct_count;
        end
    end
endmodule // io_link_address_windows

// File: io_link_chk.sv
`timescale 1ns/1ps
// sees only the bridge ports
module io_link_chk #(
    parameter int BEAT_W = 4
) (
    input wire logic clk_sys_in,
    input wire logic reset_n_in,
    input wire logic [39:0] cpu_req_addr_in,
    input wire logic cpu_req_valid_in,
    input wire logic cpu_req_write_in,
    input wire logic cpu_req_fetch_in,
    input wire logic cpu_req_ready_out,
    input wire logic link_req_valid_out,
    input wire logic [39:0] link_req_addr_out,
    input wire logic cpu_invalid_beat_out,
    input wire logic cpu_invalid_last_out,
    input wire logic cpu_write_done_out,
    input wire logic in_req_valid_in,
    input wire logic [39:0] in_req_addr_in,
    input wire logic mem_req_valid_out,
    input wire logic [53:0] mem_req_addr_out,
    input wire io_link_pkg::route_type mem_req_route_out,
    input wire logic mem_req_l1_invalidate_out
);
    import io_link_pkg::*;
    localparam int DRAIN_MAX = (1 << BEAT_W) - 1;
    // a core request is taken where valid meets ready
    wire take = cpu_req_valid_in && cpu_req_ready_out;
    default clocking @(posedge clk_sys_in);
    endclocking
    default disable iff (!reset_n_in);

    a_inbound_answered: assert property (in_req_valid_in |=> mem_req_valid_out)
        else $error("inbound request lost");
    a_bypass_no_inval: assert property (mem_req_valid_out &&
        mem_req_route_out == ROUTE_DIRECT |-> !mem_req_l1_invalidate_out)
        else $error("bypass invalidated l1");
    a_miss_coherent: assert property (mem_req_valid_out &&
        mem_req_route_out == ROUTE_COHERENT |-> mem_req_l1_invalidate_out &&
        mem_req_addr_out == {14'h0, $past(in_req_addr_in)})
        else $error("coherent request altered");
    a_idle_quiet: assert property (!mem_req_valid_out |->
        !mem_req_l1_invalidate_out && mem_req_route_out == ROUTE_COHERENT)
        else $error("idle side not quiet");
    a_plain_forward: assert property (take && !cpu_req_fetch_in |=>
        link_req_valid_out && link_req_addr_out == $past(cpu_req_addr_in))
        else $error("plain traffic altered");
    a_one_answer: assert property (take && cpu_req_fetch_in |=>
        $onehot({link_req_valid_out, cpu_write_done_out, cpu_invalid_beat_out}))
        else $error("fetch answer not unique");
    a_read_no_done: assert property (take && !cpu_req_write_in |=> !cpu_write_done_out)
        else $error("read got a write done");
    a_drain_stall: assert property (cpu_invalid_beat_out && !cpu_invalid_last_out
        |-> !cpu_req_ready_out ##1 cpu_invalid_beat_out)
        else $error("beat train broken");
    a_last_is_beat: assert property (cpu_invalid_last_out |-> cpu_invalid_beat_out)
        else $error("last flag without beat");
    a_drain_bound: assert property ($rose(cpu_invalid_beat_out) |->
        ##[0:DRAIN_MAX] cpu_invalid_last_out)
        else $error("beat train too long");

    c_plain: cover property (take && !cpu_req_fetch_in);
    c_last: cover property (cpu_invalid_beat_out ##1 cpu_invalid_last_out);
    c_bypass: cover property (mem_req_valid_out && mem_req_route_out == ROUTE_DIRECT);
endmodule // io_link_chk

bind io_link_address_windows io_link_chk #(.BEAT_W(BEAT_W)) u_chk (.*);

// File: link_peer_model.sv
`timescale 1ns/1ps
// link peer: issues one inbound request per call
module link_peer_model (
    input wire logic clk_sys_in,
    output logic in_req_valid_out,
    output logic [39:0] in_req_addr_out,
    output logic in_req_write_out
);
    initial {in_req_valid_out, in_req_addr_out, in_req_write_out} = '0;
    // idle lines show the inverse, so a stale address never passes
    task automatic send(input logic [39:0] a, input logic w);
        @(posedge clk_sys_in);
        {in_req_valid_out, in_req_addr_out, in_req_write_out} <= {1'b1, a, w};
        @(posedge clk_sys_in);
        {in_req_valid_out, in_req_addr_out, in_req_write_out} <= {1'b0, ~a, ~w};
    endtask
endmodule // link_peer_model

// File: test_io_link_address_windows.sv
`timescale 1ns/1ps
`include "io_link_defs.svh"
module test_io_link_address_windows;
    import io_link_pkg::*;
    logic clk_sys_in, reset_n_in, reg_write_in, reg_read_in;
    logic [7:0] reg_addr_in;
    logic [31:0] reg_wdata_in, reg_rdata_out, r;
    logic cpu_req_valid_in, cpu_req_write_in, cpu_req_fetch_in, cpu_req_ready_out;
    logic [39:0] cpu_req_addr_in, link_req_addr_out, in_req_addr_in, addr;
    logic [3:0] cpu_req_len_in;
    logic link_req_valid_out, link_req_write_out, cpu_invalid_beat_out;
    logic cpu_invalid_last_out, cpu_write_done_out, in_req_valid_in, in_req_write_in;
    logic mem_req_valid_out, mem_req_write_out, mem_req_l1_invalidate_out;
    logic [53:0] mem_req_addr_out;
    route_type mem_req_route_out;
    int n_errors = 0, checks = 0, seed = 37158;
    logic [31:0] img [8] = '{default: 32'h0}; // bench copy of registers 0xe0 up
    logic [15:0] n_miss = 16'h0, n_hit = 16'h0;

    io_link_address_windows u_dut (.*);
    link_peer_model u_peer (.clk_sys_in(clk_sys_in), .in_req_valid_out(in_req_valid_in),
        .in_req_addr_out(in_req_addr_in), .in_req_write_out(in_req_write_in));

    initial begin
        clk_sys_in = 1'b0;
        forever #25 clk_sys_in = ~clk_sys_in;
    end

    task automatic tally_and_finish;
        if (n_errors == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic cmp(input logic [53:0] got, input logic [53:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    function automatic logic hit(logic on, logic [31:0] bm, logic [39:0] a);
        return on && ((a[39:24] & bm[15:0]) == (bm[31:16] & bm[15:0]));
    endfunction
    function automatic logic [15:0] mix(logic [31:0] bm, logic [15:0] x, logic [39:0] a);
        return (a[39:24] & ~bm[15:0]) | (x & bm[15:0]);
    endfunction

    // prefetch enable keeps only bit 31 and the low half
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        {reg_write_in, reg_addr_in, reg_wdata_in} <= {1'b1, a, d};
        @(posedge clk_sys_in);
        reg_write_in <= 1'b0;
        if (a >= 8'he0 && a[1:0] == 2'b00)
            img[(a - 8'he0) >> 2] = (!a[4] && !a[2]) ? d & 32'h8000_ffff : d;
    endtask
    task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys_in);
        {reg_read_in, reg_addr_in} <= {1'b1, a};
        @(posedge clk_sys_in);
        reg_read_in <= 1'b0;
        @(negedge clk_sys_in);
        cmp(reg_rdata_out, exp, "read data");
    endtask

    // window 0 wins an overlap
    task automatic inbound(input logic [39:0] a, input logic w);
        logic h0, h1, h;
        logic [31:0] en, bm;
        logic [53:0] exp;
        h0 = hit(img[4][31], img[5], a);
        h1 = hit(img[6][31], img[7], a);
        h = h0 | h1;
        en = h0 ? img[4] : img[6];
        bm = h0 ? img[5] : img[7];
        exp = {14'h0, a};
        if (h && en[30]) exp = {en[29:16], mix(bm, en[15:0], a), a[23:0]};
        if (h) n_hit++;
        u_peer.send(a, w);
        @(negedge clk_sys_in);
        cmp(mem_req_valid_out, 1'b1, "mem valid");
        cmp(mem_req_addr_out, exp, "mem addr");
        cmp(mem_req_route_out, h ? ROUTE_DIRECT : ROUTE_COHERENT, "route");
        cmp(mem_req_l1_invalidate_out, !h, "l1 invalidate");
        cmp(mem_req_write_out, w, "mem write");
    endtask

    // one request after ready; a miss owes a done pulse or n+1 beats
    task automatic core(input logic [39:0] a, input logic w, input logic f, input logic [3:0] n);
        logic h0, h1;
        logic [39:0] exp;
        int k;
        h0 = hit(img[0][31], img[1], a);
        h1 = hit(img[2][31], img[3], a);
        exp = a;
        if (f && h0) exp[39:24] = mix(img[1], img[0][15:0], a);
        else if (f && h1) exp[39:24] = mix(img[3], img[2][15:0], a);
        @(negedge clk_sys_in);
        for (k = 0; k < 40 && cpu_req_ready_out !== 1'b1; k++) @(negedge clk_sys_in);
        cmp(cpu_req_ready_out, 1'b1, "ready");
        @(posedge clk_sys_in);
        {cpu_req_valid_in, cpu_req_addr_in, cpu_req_write_in, cpu_req_fetch_in, cpu_req_len_in}
            <= {1'b1, a, w, f, n};
        @(posedge clk_sys_in);
        cpu_req_valid_in <= 1'b0;
        @(negedge clk_sys_in);
        if (!f || h0 || h1) begin
            cmp(link_req_valid_out, 1'b1, "link valid");
            cmp(link_req_addr_out, exp, "link addr");
            cmp(link_req_write_out, w, "link write");
        end else if (w) begin
            n_miss++;
            cmp(cpu_write_done_out, 1'b1, "write done");
        end else begin
            n_miss++;
            for (k = 0; k <= n; k++) begin
                cmp({cpu_invalid_beat_out, cpu_invalid_last_out}, {1'b1, k == n}, "beat");
                @(negedge clk_sys_in);
            end
            cmp(cpu_invalid_beat_out, 1'b0, "beat count");
        end
    endtask

    // watchdog: the run needs under a thousand cycles
    initial begin
        #(50 * 20000);
        n_errors++;
        tally_and_finish();
    end

    initial begin
        reset_n_in = 1'b0;
        {reg_write_in, reg_read_in, reg_addr_in, reg_wdata_in, cpu_req_valid_in} = '0;
        {cpu_req_write_in, cpu_req_fetch_in, cpu_req_addr_in, cpu_req_len_in} = '0;
        repeat (6) @(posedge clk_sys_in);
        reset_n_in <= 1'b1;
        for (int i = 0; i < 8; i++) reg_rd(8'he0 + 8'(i * 4), 32'h0);
        // random images, then an unmapped write
        for (int i = 0; i < 16; i++) begin
            r = $random(seed);
            reg_wr(8'he0 + 8'(i % 8 * 4), r);
            reg_rd(8'he0 + 8'(i % 8 * 4), img[i % 8]);
        end
        reg_wr(8'h40, 32'hffff_ffff);
        reg_rd(8'h40, 32'h0);
        // uncache window 0 remaps, window 1 passes through, both overlap at 0x12
        reg_wr(`OFS_NC_WIN0_ENABLE, 32'hc000_0000 | ($random(seed) & 32'h3fff_ffff));
        reg_wr(`OFS_NC_WIN0_BASE, 32'h1200_ff00);
        reg_wr(`OFS_NC_WIN1_ENABLE, 32'h8000_0000);
        reg_wr(`OFS_NC_WIN1_BASE, 32'h1234_f000);
        for (int i = 0; i < 60; i++) begin
            addr = 40'({$random(seed), $random(seed)});
            if (i % 3 == 0) addr[39:32] = 8'h12;
            if (i % 3 == 1) addr[39:32] = 8'h17;
            inbound(addr, addr[0]);
        end
        // prefetch windows; core addresses inside uncache windows must miss
        reg_wr(`OFS_PF_WIN0_ENABLE, 32'h8000_abcd);
        reg_wr(`OFS_PF_WIN0_BASE, 32'h0300_ff00);
        reg_wr(`OFS_PF_WIN1_ENABLE, 32'h8000_5a5a);
        reg_wr(`OFS_PF_WIN1_BASE, 32'h0400_fc00);
        core(40'h12_0000_0000, 1'b0, 1'b1, 4'hf);
        for (int i = 0; i < 40; i++) begin
            addr = 40'({$random(seed), $random(seed)});
            r = $random(seed);
            addr[39:32] = (i % 4 == 0) ? 8'h03 : (i % 4 == 1) ? {6'h1, r[7:6]} : addr[39:32];
            core(addr, r[0], r[1] | (i % 4 != 3), r[5:2]);
        end
        reg_wr(`OFS_PF_WIN1_ENABLE, 32'h0000_5a5a);
        core(40'h04_1111_1111, 1'b0, 1'b1, 4'h0);
        // both uncache windows off: even a remap bit gives no hit
        reg_wr(`OFS_NC_WIN0_ENABLE, 32'h7fff_ffff);
        reg_wr(`OFS_NC_WIN1_ENABLE, 32'h0);
        inbound(40'h12_3456_789a, 1'b1);
        reg_rd(`OFS_WIN_STATUS, {n_miss, n_hit});
        tally_and_finish();
    end
endmodule // test_io_link_address_windows
